//--- rtl/exec_unit.sv
/*
 * Execution block: APB-programmed instruction issue, flags, branches, accumulators.
 * Assumes an APB master on the same clock; operands are staged in OPA and OPB.
 */
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module exec_unit (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        resetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Execution events
   output logic             exec_done,
   output logic             dest_is_default_work_reg
);

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic [15:0] opa;
      logic [15:0] opb;
      logic [8:0]  status;
      logic [15:0] result;
      logic [15:0] pc;
      logic [39:0] acca;
      logic [39:0] accb;
      logic [2:0]  cnt;
      logic        dest_default_work_reg;
   } state_t;

   state_t st_r;
   state_t st_nxt;

   logic               acc_wr;
   logic               mapped;
   logic               busy;
   logic               issue;
   exec_pkg::op_t      op;
   exec_pkg::form_t    form;
   exec_pkg::cond_t    cond;
   logic [3:0]         bitnum;
   logic               sfr;
   logic               acc_sel;
   logic [15:0]        opb_m;
   logic [15:0]        alu_res;
   logic               f_c;
   logic               f_dc;
   logic               f_ov;
   logic               f_n;
   logic               f_z;
   logic               take;
   logic               is_branch;
   logic [39:0]        acc_x;
   logic [39:0]        acc_y;
   logic [40:0]        acc_s;
   logic [39:0]        acc_new;
   logic               sat;

   assign busy    = (st_r.cnt != 3'h0);
   assign acc_wr  = psel && penable && pwrite;
   assign issue   = acc_wr && (paddr == exec_pkg::OFS_INSTR) && !busy;
   assign op      = exec_pkg::op_t'(pwdata[exec_pkg::INS_OP_LSB +: 4]);
   assign form    = exec_pkg::form_t'(pwdata[exec_pkg::INS_FORM_LSB +: 3]);
   assign cond    = exec_pkg::cond_t'(pwdata[exec_pkg::INS_COND_LSB +: 5]);
   assign bitnum  = pwdata[exec_pkg::INS_BIT_LSB +: 4];
   assign sfr     = pwdata[exec_pkg::INS_SFR];
   assign acc_sel = pwdata[exec_pkg::INS_ACC_SEL];
   assign is_branch = (op == exec_pkg::OP_BRA_COND) || (op == exec_pkg::OP_BRA_ALWAYS)
                      || (op == exec_pkg::OP_BRA_COMPUTED);

   // ****************************************
   // Literal width masking
   // ****************************************
   always_comb begin
      case (form)
         exec_pkg::FORM_LIT10: opb_m = {6'h00, st_r.opb[9:0]};   // RL2
         exec_pkg::FORM_LIT5:  opb_m = {11'h000, st_r.opb[4:0]}; // RL2
         default:              opb_m = st_r.opb;
      endcase
   end

   // ****************************************
   // Arithmetic core and branch decision
   // ****************************************
   alu16 u_alu (
      .op     (op),
      .bitnum (bitnum),
      .a      (st_r.opa),
      .b      (opb_m),
      .cin    (st_r.status[exec_pkg::ST_C]),
      .res    (alu_res),
      .c      (f_c),
      .dc     (f_dc),
      .ov     (f_ov),
      .n      (f_n),
      .z      (f_z)
   );

   branch_cond u_cond (
      .cond  (cond),
      .flags (st_r.status),
      .take  (take)
   );

   // ****************************************
   // Accumulator adder
   // ****************************************
   always_comb begin
      acc_x = acc_sel ? st_r.accb : st_r.acca;
      if (op == exec_pkg::OP_ADD_ACC) begin
         acc_y = acc_sel ? st_r.acca : st_r.accb;
      end else begin
         acc_y = {{8{st_r.opa[15]}}, st_r.opa, 16'h0000};        // RL1
      end
      acc_s = {acc_x[39], acc_x} + {acc_y[39], acc_y};
      sat   = (acc_s[40] != acc_s[39]);
      if (sat) begin
         acc_new = acc_s[40] ? {1'b1, 39'h0} : {1'b0, {39{1'b1}}};
      end else begin
         acc_new = acc_s[39:0];
      end
   end

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      st_nxt = st_r;
      if (busy) begin
         st_nxt.cnt = st_r.cnt - 3'h1;
      end
      if (acc_wr && (paddr == exec_pkg::OFS_OPA)) begin
         st_nxt.opa = pwdata[15:0];
      end
      if (acc_wr && (paddr == exec_pkg::OFS_OPB)) begin
         st_nxt.opb = pwdata[15:0];
      end
      if (acc_wr && (paddr == exec_pkg::OFS_STATUS)) begin
         st_nxt.status = pwdata[8:0];
      end
      if (acc_wr && (paddr == exec_pkg::OFS_PC) && !busy) begin
         st_nxt.pc = pwdata[15:0];
      end
      if (issue) begin
         st_nxt.cnt = exec_pkg::CYC_BASE;
         st_nxt.pc  = st_r.pc + 16'h0001;
         case (op)
            exec_pkg::OP_ADD_ACC, exec_pkg::OP_ADD_SACC: begin
               if (acc_sel) begin
                  st_nxt.accb = acc_new;
                  st_nxt.status[exec_pkg::ST_SB] = st_r.status[exec_pkg::ST_SB] | sat;          // RL1
                  st_nxt.status[exec_pkg::ST_OB] = (acc_new[39:31] != {9{acc_new[31]}});
               end else begin
                  st_nxt.acca = acc_new;
                  st_nxt.status[exec_pkg::ST_SA] = st_r.status[exec_pkg::ST_SA] | sat;          // RL1
                  st_nxt.status[exec_pkg::ST_OA] = (acc_new[39:31] != {9{acc_new[31]}});
               end
            end
            exec_pkg::OP_ADD, exec_pkg::OP_ADD_WITH_CARRY_OP: begin
               st_nxt.result = alu_res;
               st_nxt.status[exec_pkg::ST_C]  = f_c;                // RL2 RL3
               st_nxt.status[exec_pkg::ST_DC] = f_dc;               // RL17
               st_nxt.status[exec_pkg::ST_OV] = f_ov;
               st_nxt.status[exec_pkg::ST_N]  = f_n;
               st_nxt.status[exec_pkg::ST_Z]  = f_z;
            end
            exec_pkg::OP_AND, exec_pkg::OP_ASRN: begin
               st_nxt.result = alu_res;
               st_nxt.status[exec_pkg::ST_N] = f_n;                 // RL4 RL6
               st_nxt.status[exec_pkg::ST_Z] = f_z;
            end
            exec_pkg::OP_ASR1: begin
               st_nxt.result = alu_res;
               st_nxt.status[exec_pkg::ST_C]  = f_c;                // RL5
               st_nxt.status[exec_pkg::ST_OV] = f_ov;
               st_nxt.status[exec_pkg::ST_N]  = f_n;
               st_nxt.status[exec_pkg::ST_Z]  = f_z;
            end
            exec_pkg::OP_BIT_CLEAR_OP: st_nxt.result = alu_res;             // RL7
            exec_pkg::OP_BRA_COND: begin
               if (take) begin
                  st_nxt.cnt = exec_pkg::CYC_TAKEN;                 // RL12
                  st_nxt.pc  = st_r.pc + 16'h0001 + st_r.opb;
               end
            end
            exec_pkg::OP_BRA_ALWAYS, exec_pkg::OP_BRA_COMPUTED: begin
               st_nxt.cnt = exec_pkg::CYC_TAKEN;                    // RL13 RL14
               st_nxt.pc  = st_r.pc + 16'h0001 + st_r.opb;
            end
            default: st_nxt.cnt = exec_pkg::CYC_BASE;
         endcase
         if (sfr && !is_branch) begin
            st_nxt.cnt = exec_pkg::CYC_BASE + exec_pkg::CYC_SFR;    // RL15
         end
         st_nxt.dest_default_work_reg = (form != exec_pkg::FORM_F_TO_F);
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         st_r        <= '0;
         st_r.status <= exec_pkg::STATUS_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ****************************************
   // APB read side
   // ****************************************
   always_comb begin
      mapped = 1'b1;
      prdata = 32'h0000_0000;
      case (paddr)
         exec_pkg::OFS_INSTR:  prdata = 32'h0000_0000;
         exec_pkg::OFS_OPA:    prdata = {16'h0000, st_r.opa};
         exec_pkg::OFS_OPB:    prdata = {16'h0000, st_r.opb};
         exec_pkg::OFS_STATUS: prdata = {16'h0000, busy, 6'h00, st_r.status};
         exec_pkg::OFS_RESULT: prdata = {16'h0000, st_r.result};
         exec_pkg::OFS_PC:     prdata = {16'h0000, st_r.pc};
         exec_pkg::OFS_ACCA:   prdata = st_r.acca[31:0];
         exec_pkg::OFS_ACCB:   prdata = st_r.accb[31:0];
         default:              mapped = 1'b0;
      endcase
   end

   assign pready       = 1'b1;
   assign pslverr      = psel && penable && !mapped;
   assign exec_done    = (st_r.cnt == 3'h1);
   assign dest_is_default_work_reg = st_r.dest_default_work_reg;

   // ****************************************
   // Checks
   // ****************************************
   sequence s_busy_four;
      busy [*4] ##1 !busy;
   endsequence

   sequence s_busy_two;
      busy [*2] ##1 !busy;
   endsequence

   sequence s_busy_one;
      busy ##1 !busy;
   endsequence

   property p_taken_four;
      @(posedge clk) disable iff (!resetn)
      (issue && op == exec_pkg::OP_BRA_COND && take) |=> s_busy_four;
   endproperty
   a_taken_four: assert property (p_taken_four) else $error("taken branch not four cycles"); // RL12

   property p_untaken_one;
      @(posedge clk) disable iff (!resetn)
      (issue && op == exec_pkg::OP_BRA_COND && !take) |=> s_busy_one;
   endproperty
   a_untaken_one: assert property (p_untaken_one) else $error("untaken branch not one cycle"); // RL12

   property p_always_four;
      @(posedge clk) disable iff (!resetn)
      (issue && (op == exec_pkg::OP_BRA_ALWAYS || op == exec_pkg::OP_BRA_COMPUTED))
      |=> s_busy_four;
   endproperty
   a_always_four: assert property (p_always_four) else $error("unconditional branch not four cycles"); // RL13

   property p_computed_pc;
      @(posedge clk) disable iff (!resetn)
      (issue && op == exec_pkg::OP_BRA_COMPUTED) |=> st_r.pc == $past(st_r.pc) + 16'h0001 + $past(st_r.opb);
   endproperty
   a_computed_pc: assert property (p_computed_pc) else $error("computed branch target wrong"); // RL14

   property p_branch_flags;
      @(posedge clk) disable iff (!resetn)
      (issue && is_branch) |=> st_r.status == $past(st_r.status);
   endproperty
   a_branch_flags: assert property (p_branch_flags) else $error("branch changed flags"); // RL12

   property p_sfr_extra;
      @(posedge clk) disable iff (!resetn)
      (issue && sfr && !is_branch) |=> s_busy_two;
   endproperty
   a_sfr_extra: assert property (p_sfr_extra) else $error("peripheral access missing extra cycle"); // RL15

   property p_bit_clear_op;
      @(posedge clk) disable iff (!resetn)
      (issue && op == exec_pkg::OP_BIT_CLEAR_OP) |=> !st_r.result[$past(bitnum)] && st_r.status == $past(st_r.status);
   endproperty
   a_bit_clear_op: assert property (p_bit_clear_op) else $error("bit clear wrong"); // RL7

   property p_and_flags;
      @(posedge clk) disable iff (!resetn)
      (issue && op == exec_pkg::OP_AND) |=> st_r.status[exec_pkg::ST_C] == $past(st_r.status[exec_pkg::ST_C])
         && st_r.status[exec_pkg::ST_OV] == $past(st_r.status[exec_pkg::ST_OV]);
   endproperty
   a_and_flags: assert property (p_and_flags) else $error("AND touched carry or overflow"); // RL4

   property p_acc_flags;
      @(posedge clk) disable iff (!resetn)
      (issue && (op == exec_pkg::OP_ADD_ACC || op == exec_pkg::OP_ADD_SACC))
      |=> st_r.status[4:0] == $past(st_r.status[4:0]);
   endproperty
   a_acc_flags: assert property (p_acc_flags) else $error("accumulator add touched core flags"); // RL1

   property p_asr_carry;
      @(posedge clk) disable iff (!resetn)
      (issue && op == exec_pkg::OP_ASR1) |=> st_r.status[exec_pkg::ST_C] == $past(st_r.opa[0])
         && st_r.result[15] == $past(st_r.opa[15]);
   endproperty
   a_asr_carry: assert property (p_asr_carry) else $error("shift carry or sign wrong"); // RL16

endmodule : exec_unit

//--- rtl/exec_pkg.sv
/*
 * Constants, field layouts and encodings shared by the execution block.
 * Assumes a single 10 MHz instruction-cycle clock and an APB register master.
 */
// Notes on behaviour
// RL1: Accumulator sum and signed add into accumulator touch only the four accumulator flags.
// RL2: Add supports five operand forms and updates C, DC, N, OV, Z.
// RL3: Add-with-carry mirrors add, also adds carry in, same five flags.
// RL4: AND in file, literal and register forms updates only N and Z.
// RL5: Single arithmetic right shift updates C, N, OV and Z.
// RL6: Multi-position right shift by register or literal updates only N and Z.
// RL7: Bit clear clears one selected bit and leaves all flags unchanged.
// RL8: Branches exist on signed GE, GT, LE and LT outcomes.
// RL9: Branches exist on unsigned GE, GT, LE and LT outcomes.
// RL10: Branches exist on C, N, OV, Z in set and clear sense.
// RL11: Branches exist on accumulator A/B overflow and saturation flags.
// RL12: Conditional branch takes one cycle untaken, four taken, flags unchanged.
// RL13: Unconditional branch always redirects, four cycles, flags unchanged.
// RL14: Computed branch offsets by a work register value, four cycles, flags unchanged.
// RL15: Operations on peripheral registers cost one extra cycle.
// RL16: Arithmetic shifts replicate the sign bit; single shift moves bit 0 into carry.
// RL17: Digit carry is carry out of bit 3; overflow is signed overflow.
package exec_pkg;

   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [7:0] OFS_INSTR  = 8'h00;
   localparam logic [7:0] OFS_OPA    = 8'h04;
   localparam logic [7:0] OFS_OPB    = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0c;
   localparam logic [7:0] OFS_RESULT = 8'h10;
   localparam logic [7:0] OFS_PC     = 8'h14;
   localparam logic [7:0] OFS_ACCA   = 8'h18;
   localparam logic [7:0] OFS_ACCB   = 8'h1c;

   // ****************************************
   // Instruction word fields
   // ****************************************
   localparam int INS_OP_LSB   = 0;
   localparam int INS_FORM_LSB = 4;
   localparam int INS_COND_LSB = 7;
   localparam int INS_BIT_LSB  = 12;
   localparam int INS_SFR      = 16;
   localparam int INS_ACC_SEL  = 17;

   // ****************************************
   // Status bit positions
   // ****************************************
   localparam int ST_C    = 0;
   localparam int ST_Z    = 1;
   localparam int ST_OV   = 2;
   localparam int ST_N    = 3;
   localparam int ST_DC   = 4;
   localparam int ST_OA   = 5;
   localparam int ST_OB   = 6;
   localparam int ST_SA   = 7;
   localparam int ST_SB   = 8;
   localparam int ST_BUSY = 15;
   localparam logic [8:0] STATUS_RESET = 9'h000;

   // ****************************************
   // Cycle costs
   // ****************************************
   localparam logic [2:0] CYC_BASE   = 3'h1;
   localparam logic [2:0] CYC_TAKEN  = 3'h4;
   localparam logic [2:0] CYC_SFR    = 3'h1;

   // ****************************************
   // Encodings
   // ****************************************
   typedef enum logic [3:0] {
      OP_ADD_ACC, OP_ADD_SACC, OP_ADD, OP_ADD_WITH_CARRY_OP, OP_AND, OP_ASR1, OP_ASRN,
      OP_BIT_CLEAR_OP, OP_BRA_COND, OP_BRA_ALWAYS, OP_BRA_COMPUTED, OP_NOP
   } op_t;

   typedef enum logic [2:0] {
      FORM_F_TO_F, FORM_F_TO_DEFAULT_WORK_REG, FORM_LIT10, FORM_REG_REG, FORM_LIT5
   } form_t;

   typedef enum logic [4:0] {
      CND_C, CND_NC, CND_N, CND_NN, CND_OV, CND_NOV, CND_Z, CND_NZ,
      CND_GE, CND_GT, CND_LE, CND_LT, CND_GEU, CND_GTU, CND_LEU, CND_LTU,
      CND_OA, CND_OB, CND_SA, CND_SB
   } cond_t;

endpackage : exec_pkg

//--- rtl/branch_cond.sv
/*
 * Branch condition evaluation from the status flags.
 * Assumes flags arrive straight from the status register.
 */
`timescale 1ns/1ps
module branch_cond (
   // Condition select
   input  wire exec_pkg::cond_t cond,
   // Flags
   input  wire logic [8:0]      flags,
   // Decision
   output logic                 take
);
   logic c;
   logic z;
   logic v;
   logic n;
   assign c = flags[exec_pkg::ST_C];
   assign z = flags[exec_pkg::ST_Z];
   assign v = flags[exec_pkg::ST_OV];
   assign n = flags[exec_pkg::ST_N];

   // ****************************************
   // Condition decode
   // ****************************************
   always_comb begin
      case (cond)
         exec_pkg::CND_C:   take = c;                             // RL10
         exec_pkg::CND_NC:  take = !c;
         exec_pkg::CND_N:   take = n;
         exec_pkg::CND_NN:  take = !n;
         exec_pkg::CND_OV:  take = v;
         exec_pkg::CND_NOV: take = !v;
         exec_pkg::CND_Z:   take = z;
         exec_pkg::CND_NZ:  take = !z;
         exec_pkg::CND_GE:  take = (n == v);                      // RL8
         exec_pkg::CND_GT:  take = !z && (n == v);
         exec_pkg::CND_LE:  take = z || (n != v);
         exec_pkg::CND_LT:  take = (n != v);
         exec_pkg::CND_GEU: take = c;                             // RL9
         exec_pkg::CND_GTU: take = c && !z;
         exec_pkg::CND_LEU: take = !c || z;
         exec_pkg::CND_LTU: take = !c;
         exec_pkg::CND_OA:  take = flags[exec_pkg::ST_OA];        // RL11
         exec_pkg::CND_OB:  take = flags[exec_pkg::ST_OB];
         exec_pkg::CND_SA:  take = flags[exec_pkg::ST_SA];
         exec_pkg::CND_SB:  take = flags[exec_pkg::ST_SB];
         default:           take = 1'b0;
      endcase
   end
endmodule : branch_cond

//--- rtl/alu16.sv
/*
 * 16-bit arithmetic and logic core: add, add with carry, AND, shifts, bit clear.
 * Assumes operand b is already masked to its literal width.
 */
`timescale 1ns/1ps
module alu16 (
   // Operation
   input  wire exec_pkg::op_t op,
   input  wire logic [3:0]    bitnum,
   // Operands
   input  wire logic [15:0]   a,
   input  wire logic [15:0]   b,
   input  wire logic          cin,
   // Result and flags
   output logic [15:0]        res,
   output logic               c,
   output logic               dc,
   output logic               ov,
   output logic               n,
   output logic               z
);
   logic [16:0] sum;
   logic [4:0]  low;
   logic        ci;

   // ****************************************
   // Datapath
   // ****************************************
   always_comb begin
      ci  = (op == exec_pkg::OP_ADD_WITH_CARRY_OP) ? cin : 1'b0;              // RL3
      sum = {1'b0, a} + {1'b0, b} + {16'h0000, ci};              // RL2
      low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
      c   = 1'b0;
      dc  = 1'b0;
      ov  = 1'b0;
      case (op)
         exec_pkg::OP_ADD, exec_pkg::OP_ADD_WITH_CARRY_OP: begin
            res = sum[15:0];
            c   = sum[16];
            dc  = low[4];                                         // RL17
            ov  = (a[15] == b[15]) && (sum[15] != a[15]);         // RL17
         end
         exec_pkg::OP_AND:  res = a & b;                          // RL4
         exec_pkg::OP_ASR1: begin
            res = {a[15], a[15:1]};                               // RL16
            c   = a[0];                                           // RL16
         end
         exec_pkg::OP_ASRN: res = 16'($signed(a) >>> b[3:0]);     // RL6
         exec_pkg::OP_BIT_CLEAR_OP: res = a & ~(16'h0001 << bitnum);      // RL7
         default:           res = a;
      endcase
      n = res[15];
      z = (res == 16'h0000);
   end
endmodule : alu16

//--- verification/apb_host.sv
/*
 * APB host standing in for the core's decoder and data memory.
 * Assumes the zero-wait APB slave of exec_unit on the same clock.
 */
`timescale 1ns/1ps
module apb_host (
   // Clock
   input  wire logic        clk,
   // APB master side
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   initial begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h00000000;
   end

   // ****************************************
   // One transfer, held until pready
   // ****************************************
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q       = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      pwdata  <= ~d;
   endtask : xfer
endmodule : apb_host

//--- verification/tb_top.sv
/*
 * Self-checking bench: issues every operation except OP_NOP and every condition, compares with a model.
 * Assumes exec_unit register map and encodings from exec_pkg.
 */
`timescale 1ns/1ps
module tb_top;
   logic        clk;
   logic        resetn;
   logic        psel, penable, pwrite, pready, pslverr, exec_done, dest_is_default_work_reg;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic [31:0] lfsr_r;
   logic [39:0] mac [2];
   int          fail_count;
   int          n_tests;

   exec_unit u_exec_unit (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .exec_done(exec_done), .dest_is_default_work_reg(dest_is_default_work_reg));
   apb_host u_apb_host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   always #50 clk = ~clk;

   // ****************************************
   // Helpers
   // ****************************************
   task automatic rnd(output logic [31:0] v);
      lfsr_r = lfsr_r[0] ? ((lfsr_r >> 1) ^ 32'h80200003) : (lfsr_r >> 1);
      v = lfsr_r;
   endtask : rnd
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      u_apb_host.xfer(1'b1, a, d, q, e);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      logic e;
      u_apb_host.xfer(1'b0, a, 32'h00000000, q, e);
   endtask : rd
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         fail_count++;
      end
   endtask : chk_val
   task automatic chk_cyc(input int got, input int exp);
      n_tests++;
      if (got != exp) begin
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         fail_count++;
      end
   endtask : chk_cyc
   function automatic logic cond_hit(input int c, input logic [8:0] s);
      logic        ge;
      logic [19:0] t;
      ge = (s[3] == s[2]);
      t  = {s[8], s[7], s[6], s[5], !s[0], !s[0] | s[1], s[0] & !s[1], s[0], !ge, s[1] | !ge,
            !s[1] & ge, ge, !s[1], s[1], !s[2], s[2], !s[3], s[3], !s[0], s[0]};
      return t[c];
   endfunction : cond_hit
   task automatic stop_test();
      $display("counts: comparisons=%0d mismatches=%0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : stop_test

   // ****************************************
   // One instruction against the model
   // ****************************************
   task automatic run_one(input int i);
      logic [31:0] r0, r1, r2, q, msk;
      logic [15:0] a, b, bm, res, pc, epc;
      logic [8:0]  st, es;
      logic        cin;
      logic [39:0] x, y, nv;
      logic [40:0] t;
      int          op, form, cnd, bn, sfr, cyc, cost, s, sel;
      rnd(r0);
      rnd(r1);
      rnd(r2);
      op   = i % 11;
      form = i % 5;
      cnd  = i % 20;
      bn   = r2[3:0];
      sfr  = r2[4];
      a    = r0[15:0];
      b    = (op >= 8) ? {8'h00, r0[23:16]} : r1[15:0];
      st   = r1[24:16];
      pc   = {4'h0, r2[19:8]};
      wr(exec_pkg::OFS_OPA, {16'h0000, a});
      wr(exec_pkg::OFS_OPB, {16'h0000, b});
      wr(exec_pkg::OFS_STATUS, {23'h000000, st});
      wr(exec_pkg::OFS_PC, {16'h0000, pc});
      wr(exec_pkg::OFS_INSTR, 32'(op | form << 4 | cnd << 7 | bn << 12 | sfr << 16 | r2[5] << 17));
      #1;
      cyc = 1;
      while (exec_done !== 1'b1 && cyc < 20) begin
         @(posedge clk);
         #1;
         cyc++;
      end
      bm   = (form == 2) ? (b & 16'h03ff) : (form == 4) ? (b & 16'h001f) : b;
      cin  = (op == 3) ? st[0] : 1'b0;
      es   = st;
      res  = 16'h0000;
      cost = 1 + sfr;
      epc  = pc + 16'h0001;
      sel  = r2[5];
      nv   = '0;
      case (op)
         0, 1: begin
            x  = mac[sel];
            y  = (op == 1) ? {{8{a[15]}}, a, 16'h0000} : mac[1 - sel];
            t  = {x[39], x} + {y[39], y};
            nv = (t[40] == t[39]) ? t[39:0] : t[40] ? {1'b1, 39'h0} : {1'b0, {39{1'b1}}};
            es[7 + sel] = es[7 + sel] | (t[40] != t[39]);
            es[5 + sel] = (nv[39:31] != {9{nv[31]}});
            mac[sel]    = nv;
         end
         2, 3: begin
            s     = int'(a) + int'(bm) + int'(cin);
            res   = s[15:0];
            es[0] = s[16];
            es[4] = (a[3:0] + bm[3:0] + cin) > 15;
            es[2] = (a[15] == bm[15]) && (res[15] != a[15]);
         end
         4: res = a & bm;
         5: begin
            res   = {a[15], a[15:1]};
            es[0] = a[0];
            es[2] = 1'b0;
         end
         6: res = $signed(a) >>> b[3:0];
         7: res = a & ~(16'h0001 << bn);
         8, 9, 10: begin
            cost = (op != 8 || cond_hit(cnd, st)) ? 4 : 1;
            epc  = (cost == 4) ? pc + 16'h0001 + b : epc;
         end
         default: cost = 1 + sfr;
      endcase
      if (op >= 2 && op <= 6) begin
         es[3] = res[15];
         es[1] = (res == 16'h0000);
      end
      chk_cyc(cyc, cost);
      msk = 32'hffffffff;
      rd(exec_pkg::OFS_STATUS, q);
      chk_val(q & msk, {23'h000000, es} & msk);
      if (op >= 2 && op <= 7) begin
         rd(exec_pkg::OFS_RESULT, q);
         chk_val(q, {16'h0000, res});
         chk_val({31'h0, dest_is_default_work_reg}, {31'h0, form != 0});
      end
      if (op < 2) begin
         rd(sel ? exec_pkg::OFS_ACCB : exec_pkg::OFS_ACCA, q);
         chk_val(q, nv[31:0]);
      end
      if (op >= 8) begin
         rd(exec_pkg::OFS_PC, q);
         chk_val(q, {16'h0000, epc});
      end
   endtask : run_one

   // ****************************************
   // Main sequence and watchdog
   // ****************************************
   initial begin
      logic [31:0] q;
      logic        e;
      clk        = 1'b0;
      resetn     = 1'b0;
      lfsr_r     = 32'h332c9d5a;
      fail_count = 0;
      n_tests    = 0;
      mac[0]     = '0;
      mac[1]     = '0;
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      rd(exec_pkg::OFS_STATUS, q);
      chk_val(q, 32'h00000000);
      wr(exec_pkg::OFS_RESULT, 32'h0000ffff);
      rd(exec_pkg::OFS_RESULT, q);
      chk_val(q, 32'h00000000);
      u_apb_host.xfer(1'b0, 8'h20, 32'h00000000, q, e);
      chk_val({e, q[30:0]}, 32'h80000000);
      $display("test reset and map done");
      for (int i = 0; i < 220; i++)
         run_one(i);
      $display("test instruction sweep done");
      stop_test();
   end

   initial begin
      #2000000;
      fail_count++;
      stop_test();
   end
endmodule : tb_top
